// [hw/tsc_run_ctrl.sv]
// Run control, pen flag and busy status of the shared touch converter.
module tsc_run_ctrl #(
    parameter int unsigned P_SETTLE_CYC [8] = tsc_pkg::SETTLE_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_en_n,
    input wire logic i_pen_touch,
    input wire logic i_conv_done,
    input wire logic [11:0] i_conv_data,
    output logic o_adc_power,
    output logic o_drv_en,
    output logic [3:0] o_drv_func,
    output logic o_conv_start,
    output logic [1:0] o_resolution,
    output logic [1:0] o_conv_rate,
    output logic o_result_we,
    output logic [3:0] o_result_func,
    output logic [11:0] o_result_data,
    output logic o_result_ready_n
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    for (genvar g = 0; g < 8; g++)
    begin : g_chk
        if (P_SETTLE_CYC[g] < tsc_pkg::MIN_CYC || P_SETTLE_CYC[g] >= (1 << tsc_pkg::TMR_W))
        begin : g_bad
            $error("Settling count out of timer range.");
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    tsc_reg_if u_bus ();

    tsc_spi_slave u_spi (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_spi_cs_n(i_spi_cs_n),
        .i_spi_sclk(i_spi_sclk),
        .i_spi_mosi(i_spi_mosi),
        .o_spi_miso(o_spi_miso),
        .bus(u_bus.spi)
    );

    assign o_spi_miso_en_n = i_spi_cs_n;

    tsc_pkg::tsc_state_t state;
    tsc_pkg::tsc_state_t next_state;
    logic pen_mode;
    logic armed;
    logic adc_on;
    logic drv_hold;
    logic [3:0] func;
    logic [1:0] res;
    logic [1:0] avg;
    logic [1:0] rate;
    logic [2:0] settle;
    logic [4:0] avg_cnt;
    logic [15:0] acc;

    wire ctl_sel = (u_bus.page == tsc_pkg::CTL_PAGE) && (u_bus.addr == tsc_pkg::CTL_ADDR);
    wire ctl_wr = u_bus.wr && ctl_sel;
    wire [3:0] w_func = u_bus.wdata[tsc_pkg::FUNC_LSB +: 4];
    wire w_mode = u_bus.wdata[tsc_pkg::BIT_PEN_MODE];
    // invalid code also halts
    // The invalid code ends a running scan, so no result is tagged invalid.
    wire w_stop = ctl_wr && (u_bus.wdata[tsc_pkg::BIT_RUN_HALT]
        || (w_func == tsc_pkg::FUNC_INVALID));
    wire w_go = ctl_wr && !u_bus.wdata[tsc_pkg::BIT_RUN_HALT];
    wire busy = (state != tsc_pkg::ST_IDLE);

    // top two read bits show status, not the written mode and run bits
    wire [15:0] ctl_rdata = {i_pen_touch, !busy, func, res, avg, rate, settle, 1'b0};
    assign u_bus.rdata = ctl_sel ? ctl_rdata : 16'h0000;

    // ------------------------------------------------------------
    // Start and continuation decode
    // ------------------------------------------------------------
    // code zero never converts
    wire w_valid = (w_func != tsc_pkg::FUNC_INVALID) && (w_func < tsc_pkg::FUNC_DRV_FIRST);
    wire touch_func = (func != tsc_pkg::FUNC_INVALID) && (func <= tsc_pkg::FUNC_TOUCH_LAST);
    wire scan_func = (func == tsc_pkg::FUNC_SCAN_XY) || (func == tsc_pkg::FUNC_SCAN_XYZ);
    // host start only in host mode
    wire host_start = w_go && !w_mode && w_valid;
    // touch starts conversion in self mode
    wire self_start = (state == tsc_pkg::ST_IDLE) && pen_mode && armed && i_pen_touch
        && touch_func && !ctl_wr;
    wire [2:0] avg_shift = (avg == 2'h0) ? 3'h0 : 3'(avg) + 3'h1;
    wire [4:0] avg_last_cnt = 5'((5'h01 << avg_shift) - 5'h01);
    wire avg_last = (avg_cnt == avg_last_cnt);
    wire [15:0] sum = acc + {4'h0, i_conv_data};
    wire [15:0] avg_val = sum >> avg_shift;
    wire last_done = (state == tsc_pkg::ST_CONVERT) && i_conv_done && avg_last;
    // scans repeat while pen stays down
    wire rescan = last_done && scan_func && i_pen_touch;
    wire tmr_done;
    wire enter_settle = !w_stop && (host_start || self_start || (rescan && !ctl_wr));

    wire [tsc_pkg::TMR_W-1:0] tmr_count = tsc_pkg::TMR_W'(P_SETTLE_CYC[settle]);

    tsc_settle_timer #(
        .W(tsc_pkg::TMR_W)
    ) u_tmr (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst || w_stop),
        .i_load(enter_settle),
        .i_count(tmr_count),
        .o_done(tmr_done)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            tsc_pkg::ST_IDLE:
                if (enter_settle)
                    next_state = tsc_pkg::ST_SETTLE;
            tsc_pkg::ST_SETTLE:
                if (tmr_done)
                    next_state = tsc_pkg::ST_CONVERT;
            tsc_pkg::ST_CONVERT:
                if (last_done)
                    next_state = tsc_pkg::ST_IDLE;
            default:
                next_state = tsc_pkg::ST_IDLE;
        endcase
        if (w_stop)
            next_state = tsc_pkg::ST_IDLE;
        else if (enter_settle)
            next_state = tsc_pkg::ST_SETTLE;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            state <= tsc_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    // mode and fields reset to defaults
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            pen_mode <= 1'b0;
            func <= tsc_pkg::FUNC_INVALID;
            res <= tsc_pkg::RES_RESET;
            avg <= tsc_pkg::AVG_RESET;
            rate <= tsc_pkg::RATE_RESET;
            settle <= tsc_pkg::SETTLE_RESET;
        end
        else if (ctl_wr)
        begin
            pen_mode <= w_mode;
            func <= w_func;
            res <= u_bus.wdata[tsc_pkg::RES_LSB +: 2];
            avg <= u_bus.wdata[tsc_pkg::AVG_LSB +: 2];
            rate <= u_bus.wdata[tsc_pkg::RATE_LSB +: 2];
            settle <= u_bus.wdata[tsc_pkg::SETTLE_LSB +: 3];
        end
    end

    // The arm flag lets a stop hold off self-driven scans even with the pen down.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            armed <= 1'b0;
            adc_on <= 1'b0;
            drv_hold <= 1'b0;
        end
        else
        begin
            if (ctl_wr)
                armed <= w_go;
            if (w_stop)
                adc_on <= 1'b0;
            else if (enter_settle)
                adc_on <= 1'b1;
            if (ctl_wr)
                drv_hold <= w_go && (w_func >= tsc_pkg::FUNC_DRV_FIRST);
        end
    end

    // ------------------------------------------------------------
    // Conversion, averaging and result hand-off
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || w_stop)
        begin
            o_conv_start <= 1'b0;
            avg_cnt <= '0;
            acc <= '0;
        end
        else
        begin
            // sample only after the settle delay
            o_conv_start <= ((state == tsc_pkg::ST_SETTLE) && tmr_done && !enter_settle)
                || ((state == tsc_pkg::ST_CONVERT) && i_conv_done && !avg_last
                && !enter_settle);
            if (enter_settle || last_done)
            begin
                avg_cnt <= '0;
                acc <= '0;
            end
            else if ((state == tsc_pkg::ST_CONVERT) && i_conv_done)
            begin
                avg_cnt <= avg_cnt + 5'h01;
                acc <= sum;
            end
        end
    end

    // store into the selected function's register
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_result_we <= 1'b0;
            o_result_func <= tsc_pkg::FUNC_INVALID;
            o_result_data <= '0;
        end
        else
        begin
            o_result_we <= last_done && !w_stop;
            if (last_done)
            begin
                o_result_func <= func;
                o_result_data <= avg_val[11:0];
            end
        end
    end

    // ready stays high through all averaged conversions
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            o_result_ready_n <= 1'b1;
        else if (enter_settle)
            o_result_ready_n <= 1'b1;
        else if (last_done && !w_stop)
            o_result_ready_n <= 1'b0;
    end

    assign o_adc_power = adc_on;
    assign o_drv_en = busy || drv_hold;
    assign o_drv_func = func;
    assign o_resolution = res;
    assign o_conv_rate = rate;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_settle_end;
        (state == tsc_pkg::ST_SETTLE) && tmr_done && !ctl_wr;
    endsequence

    sequence s_sample_go;
        o_conv_start && (state == tsc_pkg::ST_CONVERT);
    endsequence

    a_pen_flag_read: assert property (u_bus.rd && ctl_sel |-> ##1
        (u_spi.shift_out[15] == $past(i_pen_touch)))
        else $error("Pen flag not returned in top bit.");
    a_self_mode_start: assert property (self_start && !w_stop |=>
        (state == tsc_pkg::ST_SETTLE) && adc_on)
        else $error("Touch did not start a self-driven scan.");
    a_reset_defaults: assert property (!$past(i_rst) ||
        (!pen_mode && (func == tsc_pkg::FUNC_INVALID) && !busy))
        else $error("Control defaults wrong after reset.");
    a_busy_status: assert property (busy && u_bus.rd && ctl_sel |=>
        !u_spi.shift_out[tsc_pkg::BIT_RUN_HALT])
        else $error("Status bit shows idle while busy.");
    a_scan_repeat: assert property (rescan && !ctl_wr |=>
        (state == tsc_pkg::ST_SETTLE) && o_result_we && o_adc_power)
        else $error("Continuous scan did not restart.");
    a_stop_aborts: assert property (w_stop |=>
        !busy && !o_adc_power && !o_conv_start ##1 !o_result_we)
        else $error("Stop did not abort and power down.");
    a_status_after_reset: assert property ($past(i_rst) |->
        ctl_rdata[tsc_pkg::BIT_RUN_HALT])
        else $error("Status does not read idle after reset.");
    a_result_target: assert property (last_done && !w_stop |=>
        o_result_we && (o_result_func == $past(func)))
        else $error("Result not stored for selected function.");
    a_invalid_code: assert property ((func == tsc_pkg::FUNC_INVALID) |->
        !busy && !o_result_we)
        else $error("Invalid function code converted.");
    a_avg_busy: assert property ((state == tsc_pkg::ST_CONVERT) && i_conv_done && !avg_last
        && !ctl_wr |=> busy && o_result_ready_n && o_conv_start)
        else $error("Averaging ended busy indication early.");
    a_settle_sample: assert property (s_settle_end |=> s_sample_go)
        else $error("Sampling did not follow the settle delay.");
endmodule

// [hw/tsc_pkg.sv]
// Constants and types shared by the touch converter run control.
package tsc_pkg;
    // ------------------------------------------------------------
    // Clock and settling times
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_MHZ = 20;
    localparam int unsigned MIN_CYC = 1;
    localparam int unsigned TMR_W = 22;
    localparam int unsigned SETTLE_US [8] = '{0, 100, 500, 1000, 5000, 10000, 50000, 100000};

    // A zero settling time still costs one cycle of driver turn-on.
    function automatic int unsigned us_to_cyc(input int unsigned us);
        return (us * CLK_FREQ_MHZ < MIN_CYC) ? MIN_CYC : us * CLK_FREQ_MHZ;
    endfunction

    localparam int unsigned SETTLE_CYC [8] = '{us_to_cyc(SETTLE_US[0]),
        us_to_cyc(SETTLE_US[1]), us_to_cyc(SETTLE_US[2]), us_to_cyc(SETTLE_US[3]),
        us_to_cyc(SETTLE_US[4]), us_to_cyc(SETTLE_US[5]), us_to_cyc(SETTLE_US[6]),
        us_to_cyc(SETTLE_US[7])};

    // ------------------------------------------------------------
    // Serial port framing and control word location
    // ------------------------------------------------------------
    localparam int unsigned CMD_BITS = 16;
    localparam int unsigned FRAME_BITS = 32;
    localparam int unsigned CMD_READ_BIT = 15;
    localparam int unsigned PAGE_LSB = 11;
    localparam int unsigned ADDR_LSB = 5;
    localparam logic [3:0] CTL_PAGE = 4'h1;
    localparam logic [5:0] CTL_ADDR = 6'h00;

    // ------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------
    localparam int unsigned BIT_PEN_MODE = 15;
    localparam int unsigned BIT_RUN_HALT = 14;
    localparam int unsigned FUNC_LSB = 10;
    localparam int unsigned RES_LSB = 8;
    localparam int unsigned AVG_LSB = 6;
    localparam int unsigned RATE_LSB = 4;
    localparam int unsigned SETTLE_LSB = 1;
    localparam logic [3:0] FUNC_INVALID = 4'h0;
    localparam logic [3:0] FUNC_SCAN_XY = 4'h1;
    localparam logic [3:0] FUNC_SCAN_XYZ = 4'h2;
    localparam logic [3:0] FUNC_TOUCH_LAST = 4'h5;
    localparam logic [3:0] FUNC_DRV_FIRST = 4'hd;
    localparam logic [1:0] RES_RESET = 2'h0;
    localparam logic [1:0] AVG_RESET = 2'h0;
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [2:0] SETTLE_RESET = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_CONVERT = 2'b10
    } tsc_state_t;
endpackage

// [hw/tsc_reg_if.sv]
// Register access strobes between the serial port and the control word.
interface tsc_reg_if;
    logic wr;
    logic rd;
    logic [3:0] page;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport spi (output wr, output rd, output page, output addr, output wdata, input rdata);
    modport regs (input wr, input rd, input page, input addr, input wdata, output rdata);
endinterface

// [hw/tsc_settle_timer.sv]
// One-shot down counter that times the panel settling delay.
module tsc_settle_timer #(
    parameter int unsigned W = 22
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [W-1:0] i_count,
    output logic o_done
);
    logic [W-1:0] cnt;
    logic run;

    assign o_done = run && (cnt == W'(1));

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || o_done)
        begin
            run <= 1'b0;
            cnt <= '0;
        end
        else if (i_load)
        begin
            run <= 1'b1;
            cnt <= i_count;
        end
        else if (run)
            cnt <= cnt - W'(1);
    end
endmodule

// [hw/tsc_spi_slave.sv]
// Serial register port: 16-bit command then 16-bit data, mode 0.
module tsc_spi_slave (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    tsc_reg_if.spi bus
);
    logic sclk_q;
    logic [5:0] bit_cnt;
    logic [15:0] shift_in;
    logic [15:0] cmd;
    logic [15:0] shift_out;
    logic rd_pend;
    logic wr_pend;

    wire sclk_rise = i_spi_sclk && !sclk_q && !i_spi_cs_n;
    wire sclk_fall = !i_spi_sclk && sclk_q && !i_spi_cs_n;
    wire [15:0] word_in = {shift_in[14:0], i_spi_mosi};
    wire cmd_end = sclk_rise && (bit_cnt == 6'(tsc_pkg::CMD_BITS - 1));
    wire data_end = sclk_rise && (bit_cnt == 6'(tsc_pkg::FRAME_BITS - 1));

    assign bus.rd = rd_pend;
    assign bus.wr = wr_pend;
    assign bus.page = cmd[tsc_pkg::PAGE_LSB +: 4];
    assign bus.addr = cmd[tsc_pkg::ADDR_LSB +: 6];
    assign o_spi_miso = shift_out[15];

    always_ff @(posedge i_sys_clk)
    begin
        sclk_q <= i_spi_sclk;
        rd_pend <= !i_rst && cmd_end && word_in[tsc_pkg::CMD_READ_BIT];
        wr_pend <= !i_rst && data_end && !cmd[tsc_pkg::CMD_READ_BIT];
        if (i_rst || i_spi_cs_n)
            bit_cnt <= '0;
        else if (sclk_rise && bit_cnt < 6'(tsc_pkg::FRAME_BITS))
            bit_cnt <= bit_cnt + 6'(1);
        if (sclk_rise)
            shift_in <= word_in;
        if (i_rst)
            cmd <= '0;
        else if (cmd_end)
            cmd <= word_in;
        if (data_end)
            bus.wdata <= word_in;
        // The first data bit must sit on the line before the next rising edge.
        if (i_rst)
            shift_out <= '0;
        else if (rd_pend)
            shift_out <= bus.rdata;
        else if (sclk_fall && bit_cnt > 6'(tsc_pkg::CMD_BITS))
            shift_out <= {shift_out[14:0], 1'b0};
    end
endmodule

// [verif/tsc_host_model.sv]
// Host processor model that drives frames on the serial register port.
module tsc_host_model (
    input wire logic i_sys_clk,
    input wire logic i_miso,
    input wire logic i_miso_en_n,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_mosi
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame transfer
    // ------------------------------------------------------------
    // Each clock phase lasts four system cycles so the port's edge detector never misses one.
    // Read data is taken just before each rising edge, where a mode 0 master samples it.
    // mode bit sent whole
    task automatic frame(input logic [15:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] sh;
        sh = {cmd, wd};
        rd = 16'h0000;
        @(posedge i_sys_clk);
        #1 o_cs_n = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            o_mosi = sh[i];
            repeat (4) @(posedge i_sys_clk);
            #1;
            if (i < 16)
                rd[i] = (i_miso_en_n === 1'b0) ? i_miso : 1'bx;
            o_sclk = 1'b1;
            repeat (4) @(posedge i_sys_clk);
            #1 o_sclk = 1'b0;
        end
        repeat (2) @(posedge i_sys_clk);
        #1 o_cs_n = 1'b1;
        // A deselected data line must not look like a held bit.
        o_mosi = ~o_mosi;
        repeat (4) @(posedge i_sys_clk);
        #1;
    endtask
endmodule

// [verif/testbench.sv]
// Self-checking bench for the touch converter run control.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned SETTLE_TB [8] = '{1, 2, 3, 4, 5, 6, 7, 8};
    localparam logic [15:0] CMD_WR = {1'b0, tsc_pkg::CTL_PAGE, tsc_pkg::CTL_ADDR, 5'h00};
    localparam logic [15:0] CMD_RD = {1'b1, tsc_pkg::CTL_PAGE, tsc_pkg::CTL_ADDR, 5'h00};

    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_spi_cs_n;
    logic i_spi_sclk;
    logic i_spi_mosi;
    logic o_spi_miso;
    logic o_spi_miso_en_n;
    logic i_pen_touch = 1'b0;
    logic i_conv_done = 1'b0;
    logic [11:0] i_conv_data = 12'h000;
    logic o_adc_power;
    logic o_drv_en;
    logic [3:0] o_drv_func;
    logic o_conv_start;
    logic [1:0] o_resolution;
    logic [1:0] o_conv_rate;
    logic o_result_we;
    logic [3:0] o_result_func;
    logic [11:0] o_result_data;
    logic o_result_ready_n;
    int err_total = 0;
    int n_checks = 0;
    int conv_lat = 20;
    int n_results = 0;
    int n_starts = 0;
    logic [11:0] sample_next = 12'h100;
    logic [3:0] last_func = 4'h0;
    logic [11:0] last_data = 12'h000;
    logic [15:0] rd;

    always #25 i_sys_clk = ~i_sys_clk;

    tsc_run_ctrl #(.P_SETTLE_CYC(SETTLE_TB)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_spi_cs_n(i_spi_cs_n), .i_spi_sclk(i_spi_sclk), .i_spi_mosi(i_spi_mosi),
        .o_spi_miso(o_spi_miso), .o_spi_miso_en_n(o_spi_miso_en_n), .i_pen_touch(i_pen_touch),
        .i_conv_done(i_conv_done), .i_conv_data(i_conv_data), .o_adc_power(o_adc_power),
        .o_drv_en(o_drv_en), .o_drv_func(o_drv_func), .o_conv_start(o_conv_start),
        .o_resolution(o_resolution), .o_conv_rate(o_conv_rate), .o_result_we(o_result_we),
        .o_result_func(o_result_func), .o_result_data(o_result_data),
        .o_result_ready_n(o_result_ready_n));

    tsc_host_model host (.i_sys_clk(i_sys_clk), .i_miso(o_spi_miso),
        .i_miso_en_n(o_spi_miso_en_n), .o_cs_n(i_spi_cs_n), .o_sclk(i_spi_sclk),
        .o_mosi(i_spi_mosi));

    // ------------------------------------------------------------
    // Converter stand-in and result monitor
    // ------------------------------------------------------------
    // Samples step by three so an averaging slip shows in the result.
    initial
    begin
        forever
        begin
            @(posedge i_sys_clk);
            if (o_conv_start === 1'b1)
            begin
                repeat (conv_lat) @(posedge i_sys_clk);
                #1 i_conv_done = 1'b1;
                i_conv_data = sample_next;
                @(posedge i_sys_clk);
                #1 i_conv_done = 1'b0;
                i_conv_data = ~i_conv_data;
                sample_next = sample_next + 12'h003;
            end
        end
    end

    always @(posedge i_sys_clk)
    begin
        if (o_result_we === 1'b1)
        begin
            n_results++;
            last_func = o_result_func;
            last_data = o_result_data;
        end
        if (o_conv_start === 1'b1)
            n_starts++;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_ctl(input logic [15:0] val);
        logic [15:0] unused;
        host.frame(CMD_WR, val, unused);
    endtask

    task automatic rd_ctl(output logic [15:0] val);
        host.frame(CMD_RD, 16'h0000, val);
    endtask

    task automatic wait_res(input int n, input int lim);
        int k;
        k = 0;
        while (n_results < n && k < lim)
        begin
            @(posedge i_sys_clk);
            #1;
            k++;
        end
        chk("result arrived", 16'h0001, {15'h0000, n_results >= n});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_state();
        rd_ctl(rd);
        chk("ctl after reset", 16'h4000, rd);
        chk("ready after reset", 16'h0001, {15'h0000, o_result_ready_n});
        i_pen_touch = 1'b1;
        rd_ctl(rd);
        chk("pen flag down", 16'hC000, rd);
        i_pen_touch = 1'b0;
    endtask

    task automatic t_fields();
        int n0;
        n0 = n_results;
        wr_ctl(16'h03FF);
        rd_ctl(rd);
        chk("field readback", 16'h43FE, rd);
        chk("resolution", 16'h0003, {14'h0000, o_resolution});
        chk("rate", 16'h0003, {14'h0000, o_conv_rate});
        chk("invalid function results", 16'(n0), 16'(n_results));
        host.frame(16'h1000, 16'hFFFF, rd);
        host.frame(16'h9000, 16'h0000, rd);
        chk("unmapped read", 16'h0000, rd);
        rd_ctl(rd);
        chk("ctl after unmapped write", 16'h43FE, rd);
        wr_ctl(16'h0000);
    endtask

    task automatic t_host_single();
        logic [11:0] exp;
        conv_lat = 600;
        exp = sample_next;
        wr_ctl(16'h1800);
        rd_ctl(rd);
        chk("busy status", 16'h1800, rd);
        chk("driver function", 16'h0006, {12'h000, o_drv_func});
        wait_res(n_results + 1, 1000);
        chk("result function", 16'h0006, {12'h000, last_func});
        chk("result data", {4'h0, exp}, {4'h0, last_data});
        chk("ready low", 16'h0000, {15'h0000, o_result_ready_n});
        rd_ctl(rd);
        chk("idle status", 16'h5800, rd);
        conv_lat = 20;
    endtask

    task automatic t_average();
        int s0;
        logic [15:0] sum;
        s0 = n_starts;
        sum = 16'(sample_next) * 16'h0004 + 16'h0012;
        wr_ctl(16'h1C40);
        wait_res(n_results + 1, 1000);
        chk("average samples", 16'h0004, 16'(n_starts - s0));
        chk("average data", {4'h0, sum[13:2]}, {4'h0, last_data});
        s0 = n_starts;
        sum = 16'(sample_next) * 16'h0010 + 16'h0168;
        wr_ctl(16'h1CC0);
        wait_res(n_results + 1, 1000);
        chk("average16 samples", 16'h0010, 16'(n_starts - s0));
        chk("average16 data", {4'h0, sum[15:4]}, {4'h0, last_data});
    endtask

    task automatic t_scan_stop();
        int m;
        i_pen_touch = 1'b1;
        conv_lat = 100;
        wr_ctl(16'h0402);
        wait_res(n_results + 3, 3000);
        wr_ctl(16'h4402);
        chk("power after stop", 16'h0000, {15'h0000, o_adc_power});
        m = n_results;
        idle(1000);
        chk("results after stop", 16'(m), 16'(n_results));
        rd_ctl(rd);
        chk("status after stop", 16'hC402, rd);
        i_pen_touch = 1'b0;
        conv_lat = 20;
    endtask

    task automatic t_self_mode();
        int s0;
        int k;
        wr_ctl(16'h8C04);
        s0 = n_starts;
        idle(300);
        chk("self mode no pen", 16'(s0), 16'(n_starts));
        chk("driver idle", 16'h0000, {15'h0000, o_drv_en});
        i_pen_touch = 1'b1;
        k = 0;
        while (o_drv_en !== 1'b1 && k < 50)
        begin
            idle(1);
            k++;
        end
        k = 0;
        while (o_conv_start !== 1'b1 && k < 50)
        begin
            idle(1);
            k++;
        end
        chk("settle cycles", 16'(SETTLE_TB[2]), 16'(k));
        wait_res(n_results + 1, 1000);
        chk("self result function", 16'h0003, {12'h000, last_func});
        i_pen_touch = 1'b0;
        wr_ctl(16'h4000);
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // The whole run needs well under a millisecond; twice that means a hang.
    initial
    begin
        #2_000_000;
        err_total++;
        $display("MISMATCH watchdog expected finish seen timeout");
        close_out();
    end

    initial
    begin
        repeat (5) @(posedge i_sys_clk);
        #1 i_rst = 1'b0;
        t_reset_state();
        t_fields();
        t_host_single();
        t_average();
        t_scan_stop();
        t_self_mode();
        close_out();
    end
endmodule
